// *** design/bff_pkg.sv ***
// Constants and pin bundle for the bidirectional queue pair.
// Assumes a single system clock; all pins are sampled into it.
package bff_pkg;
  localparam int DEPTH = 64;
  // Register map
  localparam logic [31:0] REG_OFFSETS = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  // Four preset offsets, one byte each
  localparam logic [31:0] OFFSET_RESET = 32'h2010_0804;
  // Status fields
  localparam int ST_CNT_AB = 0;
  localparam int ST_CNT_BA = 8;
  localparam int ST_A_FLG = 16;
  localparam int ST_MAIL = 20;
  localparam int ST_B_FLG = 24;
  localparam int ST_OFF_SEL = 28;
  // Flag vector bits and their reset value
  localparam int FLG_EF = 3;
  localparam int FLG_FF = 2;
  localparam int FLG_AE = 1;
  localparam int FLG_AF = 0;
  localparam logic [3:0] FLG_RESET = 4'h1;
  // Port B size codes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_BYTE = 2'h2;
  localparam logic [1:0] SIZE_MAIL = 2'h3;

  typedef struct packed {
    logic a_clk;
    logic a_sel_n;
    logic a_en;
    logic a_wnr;
    logic a_mbx;
    logic a_pg;
    logic [35:0] a_data;
    logic b_clk;
    logic b_sel_n;
    logic b_en;
    logic b_wnr;
    logic [1:0] b_size;
    logic b_lane_n;
    logic [1:0] b_swap;
    logic b_pg;
    logic [35:0] b_data;
    logic rst_n;
    logic [1:0] offset;
    logic odd;
  } bff_pins_t;
endpackage

// *** design/bff_top.sv ***
// Bidirectional queue pair with mailboxes, parity and port B sizing.
// Assumes port clocks far slower than clk_sys: every pin passes two
// flip-flops, so each port clock level must last two clk_sys cycles.
//
// The register offsets and register access over AHB-Lite were decided locally.
module bff_top #(
  parameter int DEPTH = bff_pkg::DEPTH
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Common pins
  input wire logic device_reset_n,
  input wire logic [1:0] offset_select,
  input wire logic parity_odd_select,
  // Port A pins
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_enable,
  input wire logic port_a_write_not_read,
  input wire logic port_a_mailbox_select,
  input wire logic port_a_parity_generate,
  input wire logic [35:0] port_a_data_in,
  output logic [35:0] port_a_data_out,
  output logic port_a_data_oe,
  output logic port_a_empty_n,
  output logic port_a_full_n,
  output logic port_a_almost_empty_n,
  output logic port_a_almost_full_n,
  output logic port_a_parity_error_n,
  output logic b_to_a_mail_flag_n,
  // Port B pins
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_enable,
  input wire logic port_b_write_not_read,
  input wire logic [1:0] port_b_size_select,
  input wire logic port_b_lane_select_n,
  input wire logic [1:0] port_b_swap_select,
  input wire logic port_b_parity_generate,
  input wire logic [35:0] port_b_data_in,
  output logic [35:0] port_b_data_out,
  output logic port_b_data_oe,
  output logic port_b_empty_n,
  output logic port_b_full_n,
  output logic port_b_almost_empty_n,
  output logic port_b_almost_full_n,
  output logic port_b_parity_error_n,
  output logic a_to_b_mail_flag_n
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  if (DEPTH < 4 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two from 4 to 128");
  end

  typedef struct packed {
    bff_pkg::bff_pins_t s1;
    bff_pkg::bff_pins_t s2;
    logic a_clk_d;
    logic b_clk_d;
    logic rst_n_d;
    logic [1:0] off_sel;
    logic [31:0] offsets;
    logic [DEPTH-1:0][35:0] mem_ab;
    logic [DEPTH-1:0][35:0] mem_ba;
    logic [AW-1:0] wp_ab;
    logic [AW-1:0] rp_ab;
    logic [AW-1:0] wp_ba;
    logic [AW-1:0] rp_ba;
    logic [AW:0] cnt_ab;
    logic [AW:0] cnt_ba;
    logic [35:0] mbx_ab;
    logic [35:0] mbx_ba;
    logic mf_ab_n;
    logic mf_ba_n;
    logic [3:0] a_flg1;
    logic [3:0] a_flg;
    logic [3:0] b_flg1;
    logic [3:0] b_flg;
    logic [1:0] b_size_cap;
    logic b_lane_cap;
    logic [1:0] b_size;
    logic b_lane;
    logic [1:0] b_swap;
    logic [1:0] kw;
    logic [1:0] kr;
    logic [35:0] b_asm;
    logic [35:0] b_hold;
    logic [35:0] a_out;
    logic [35:0] b_out;
    logic a_perr_n;
    logic b_perr_n;
    logic ahb_wr;
    logic [31:0] ahb_rdata;
  } bff_state_t;

  bff_state_t s;
  bff_state_t next_s;
  bff_pkg::bff_pins_t pins;
  bff_pkg::bff_pins_t p;
  logic a_edge;
  logic b_edge;
  logic a_go;
  logic b_go;
  logic b_mail;
  logic [1:0] last_k;
  logic [7:0] off;

  // Lanes carried per port B transfer
  function automatic int lanes(logic [1:0] size);
    if (size == bff_pkg::SIZE_WORD) return 2;
    else if (size == bff_pkg::SIZE_BYTE) return 1;
    else return 4;
  endfunction

  // Bus lanes that a port B size uses
  function automatic logic [3:0] used(logic [1:0] size, logic lane_n);
    int nl;
    logic [3:0] m;
    nl = lanes(size);
    m = 4'((1 << nl) - 1);
    return lane_n ? m : 4'(m << (4 - nl));
  endfunction

  function automatic logic [3:0] lane_bad(logic [35:0] d, logic odd);
    for (int i = 0; i < 4; i++) begin
      lane_bad[i] = (^d[9*i +: 9]) != odd;
    end
  endfunction

  function automatic logic [35:0] par_gen(logic [35:0] d, logic en,
      logic odd);
    par_gen = d;
    for (int i = 0; i < 4; i++) begin
      if (en) par_gen[9*i+8] = (^d[9*i +: 8]) ^ odd;
    end
  endfunction

  // Lane i takes lane i xor x; mode 0,1,2,3 gives x 0,3,2,1
  function automatic logic [35:0] swap(logic [35:0] d, logic [1:0] mode);
    logic [1:0] x;
    x = 2'h0 - mode;
    for (int i = 0; i < 4; i++) begin
      swap[9*i +: 9] = d[9*(2'(i) ^ x) +: 9];
    end
  endfunction

  // Position of piece k inside the long word
  function automatic int piece(logic [1:0] size, logic lane_n,
      logic [1:0] k);
    int nl;
    nl = lanes(size);
    return lane_n ? int'(k) : 4 / nl - 1 - int'(k);
  endfunction

  function automatic logic [35:0] b_put(logic [35:0] w, logic [35:0] bus,
      logic [1:0] size, logic lane_n, logic [1:0] k);
    int nl;
    int pc;
    nl = lanes(size);
    pc = piece(size, lane_n, k);
    b_put = w;
    for (int j = 0; j < 4; j++) begin
      if (j < nl) begin
        b_put[9*(pc*nl+j) +: 9] = bus[9*(lane_n ? j : 4-nl+j) +: 9];
      end
    end
  endfunction

  function automatic logic [35:0] b_get(logic [35:0] w, logic [1:0] size,
      logic lane_n, logic [1:0] k);
    int nl;
    int pc;
    nl = lanes(size);
    pc = piece(size, lane_n, k);
    b_get = '0;
    for (int j = 0; j < 4; j++) begin
      if (j < nl) begin
        b_get[9*(lane_n ? j : 4-nl+j) +: 9] = w[9*(pc*nl+j) +: 9];
      end
    end
  endfunction

  // Flags wanted now: empty, full, almost empty, almost full
  function automatic logic [3:0] flags(logic [AW:0] rd, logic [AW:0] wr,
      logic [7:0] offv);
    flags[bff_pkg::FLG_EF] = rd != '0;
    flags[bff_pkg::FLG_FF] = wr != FULL;
    flags[bff_pkg::FLG_AE] = 8'(rd) > offv;
    flags[bff_pkg::FLG_AF] = 8'(FULL - wr) > offv;
  endfunction

  assign pins = '{a_clk: port_a_clock, a_sel_n: port_a_select_n,
    a_en: port_a_enable, a_wnr: port_a_write_not_read,
    a_mbx: port_a_mailbox_select, a_pg: port_a_parity_generate,
    a_data: port_a_data_in, b_clk: port_b_clock,
    b_sel_n: port_b_select_n, b_en: port_b_enable,
    b_wnr: port_b_write_not_read, b_size: port_b_size_select,
    b_lane_n: port_b_lane_select_n, b_swap: port_b_swap_select,
    b_pg: port_b_parity_generate, b_data: port_b_data_in,
    rst_n: device_reset_n, offset: offset_select,
    odd: parity_odd_select};

  assign p = s.s2;
  assign a_edge = p.a_clk & ~s.a_clk_d;
  assign b_edge = p.b_clk & ~s.b_clk_d;
  assign a_go = a_edge & ~p.a_sel_n & p.a_en & p.rst_n;
  assign b_go = b_edge & ~p.b_sel_n & p.b_en & p.rst_n;
  assign b_mail = p.b_size == bff_pkg::SIZE_MAIL;
  assign last_k = 2'(4 / lanes(s.b_size) - 1);
  assign off = s.offsets[8*s.off_sel +: 8];

  always_comb begin
    logic push_ab;
    logic pop_ab;
    logic push_ba;
    logic pop_ba;
    logic [1:0] swp;
    logic [35:0] word;
    logic [31:0] status;
    push_ab = 1'b0;
    pop_ab = 1'b0;
    push_ba = 1'b0;
    pop_ba = 1'b0;
    swp = s.b_swap;
    word = '0;
    status = '0;
    next_s = s;
    next_s.s1 = pins;
    next_s.s2 = s.s1;
    next_s.a_clk_d = p.a_clk;
    next_s.b_clk_d = p.b_clk;
    next_s.rst_n_d = p.rst_n;
    if (p.rst_n && !s.rst_n_d) next_s.off_sel = p.offset;
    if (b_edge) begin
      next_s.b_size_cap = p.b_size;
      next_s.b_lane_cap = p.b_lane_n;
      next_s.b_size = s.b_size_cap;
      next_s.b_lane = s.b_lane_cap;
    end
    // Port A read
    if (a_go && !p.a_wnr) begin
      if (p.a_mbx) begin
        next_s.a_out = par_gen(s.mbx_ba, p.a_pg, p.odd);
        next_s.mf_ba_n = 1'b1;
      end else if (s.a_flg[bff_pkg::FLG_EF]) begin
        next_s.a_out = par_gen(s.mem_ba[s.rp_ba], p.a_pg, p.odd);
        pop_ba = 1'b1;
      end
    end
    // Port B read
    if (b_go && !p.b_wnr) begin
      if (b_mail) begin
        next_s.b_out = par_gen(s.mbx_ab, p.b_pg, p.odd);
        next_s.mf_ab_n = 1'b1;
      end else if (s.kr != 2'h0) begin
        word = par_gen(s.b_hold, p.b_pg, p.odd);
        next_s.b_out = b_get(word, s.b_size, s.b_lane, s.kr);
        next_s.kr = (s.kr == last_k) ? 2'h0 : s.kr + 2'h1;
      end else if (s.b_flg[bff_pkg::FLG_EF]) begin
        word = swap(s.mem_ab[s.rp_ab], p.b_swap);
        next_s.b_hold = word;
        word = par_gen(word, p.b_pg, p.odd);
        next_s.b_out = b_get(word, s.b_size, s.b_lane, 2'h0);
        next_s.kr = (last_k == 2'h0) ? 2'h0 : 2'h1;
        pop_ab = 1'b1;
      end
    end
    // Port A write, after the B read so a new letter wins
    if (a_go && p.a_wnr) begin
      if (p.a_mbx) begin
        if (s.mf_ab_n) begin
          next_s.mbx_ab = p.a_data;
          next_s.mf_ab_n = 1'b0;
        end
      end else if (s.a_flg[bff_pkg::FLG_FF] && s.cnt_ab != FULL) begin
        next_s.mem_ab[s.wp_ab] = p.a_data;
        push_ab = 1'b1;
      end
    end
    // Port B write, pieces gathered into one long word
    if (b_go && p.b_wnr) begin
      if (b_mail) begin
        if (s.mf_ba_n) begin
          next_s.mbx_ba = p.b_data;
          next_s.mf_ba_n = 1'b0;
        end
      end else begin
        swp = (s.kw == 2'h0) ? p.b_swap : s.b_swap;
        word = b_put(s.b_asm, p.b_data, s.b_size, s.b_lane, s.kw);
        next_s.b_asm = word;
        next_s.b_swap = swp;
        next_s.kw = (s.kw == last_k) ? 2'h0 : s.kw + 2'h1;
        if (s.kw == last_k && s.b_flg[bff_pkg::FLG_FF] &&
            s.cnt_ba != FULL) begin
          next_s.mem_ba[s.wp_ba] = swap(word, swp);
          push_ba = 1'b1;
        end
      end
    end
    next_s.wp_ab = s.wp_ab + AW'(push_ab);
    next_s.rp_ab = s.rp_ab + AW'(pop_ab);
    next_s.wp_ba = s.wp_ba + AW'(push_ba);
    next_s.rp_ba = s.rp_ba + AW'(pop_ba);
    next_s.cnt_ab = s.cnt_ab + (AW+1)'(push_ab) - (AW+1)'(pop_ab);
    next_s.cnt_ba = s.cnt_ba + (AW+1)'(push_ba) - (AW+1)'(pop_ba);
    if (a_edge) begin
      next_s.a_flg1 = flags(s.cnt_ba, s.cnt_ab, off);
      next_s.a_flg = next_s.a_flg1 & s.a_flg1;
    end
    if (b_edge) begin
      next_s.b_flg1 = flags(s.cnt_ab, s.cnt_ba, off);
      next_s.b_flg = next_s.b_flg1 & s.b_flg1;
    end
    next_s.a_perr_n = ~|lane_bad(p.a_data, p.odd) |
      (~p.a_wnr & p.a_mbx & p.a_pg);
    next_s.b_perr_n = ~|(lane_bad(p.b_data, p.odd) &
      (b_mail ? 4'hf : used(s.b_size, s.b_lane))) |
      (~p.b_wnr & b_mail & p.b_pg);
    if (!p.rst_n) begin
      next_s.wp_ab = '0;
      next_s.rp_ab = '0;
      next_s.wp_ba = '0;
      next_s.rp_ba = '0;
      next_s.cnt_ab = '0;
      next_s.cnt_ba = '0;
      next_s.mf_ab_n = 1'b1;
      next_s.mf_ba_n = 1'b1;
      next_s.a_flg1 = bff_pkg::FLG_RESET;
      next_s.a_flg = bff_pkg::FLG_RESET;
      next_s.b_flg1 = bff_pkg::FLG_RESET;
      next_s.b_flg = bff_pkg::FLG_RESET;
      next_s.b_size_cap = bff_pkg::SIZE_LONG;
      next_s.b_size = bff_pkg::SIZE_LONG;
      next_s.kw = 2'h0;
      next_s.kr = 2'h0;
    end
    // Register bus: data phase write, address phase read capture
    status[bff_pkg::ST_CNT_AB +: 8] = 8'(s.cnt_ab);
    status[bff_pkg::ST_CNT_BA +: 8] = 8'(s.cnt_ba);
    status[bff_pkg::ST_A_FLG +: 4] = s.a_flg;
    status[bff_pkg::ST_MAIL +: 2] = {s.mf_ba_n, s.mf_ab_n};
    status[bff_pkg::ST_B_FLG +: 4] = s.b_flg;
    status[bff_pkg::ST_OFF_SEL +: 2] = s.off_sel;
    next_s.ahb_wr = 1'b0;
    if (s.ahb_wr) next_s.offsets = hwdata;
    if (hsel && hready && htrans[1]) begin
      next_s.ahb_wr = hwrite && hsize == 3'h2 &&
        haddr == bff_pkg::REG_OFFSETS;
      if (hwrite) next_s.ahb_rdata = '0;
      else if (haddr == bff_pkg::REG_OFFSETS) next_s.ahb_rdata = s.offsets;
      else if (haddr == bff_pkg::REG_STATUS) next_s.ahb_rdata = status;
      else next_s.ahb_rdata = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.offsets <= bff_pkg::OFFSET_RESET;
      s.mf_ab_n <= 1'b1;
      s.mf_ba_n <= 1'b1;
      s.a_flg1 <= bff_pkg::FLG_RESET;
      s.a_flg <= bff_pkg::FLG_RESET;
      s.b_flg1 <= bff_pkg::FLG_RESET;
      s.b_flg <= bff_pkg::FLG_RESET;
      s.a_perr_n <= 1'b1;
      s.b_perr_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.ahb_rdata;
  assign port_a_data_out = s.a_out;
  assign port_a_data_oe = ~p.a_sel_n & ~p.a_wnr;
  assign port_b_data_oe = ~p.b_sel_n & ~p.b_wnr;
  assign port_b_data_out = s.b_out;
  assign port_a_empty_n = s.a_flg[bff_pkg::FLG_EF];
  assign port_a_full_n = s.a_flg[bff_pkg::FLG_FF];
  assign port_a_almost_empty_n = s.a_flg[bff_pkg::FLG_AE];
  assign port_a_almost_full_n = s.a_flg[bff_pkg::FLG_AF];
  assign port_b_empty_n = s.b_flg[bff_pkg::FLG_EF];
  assign port_b_full_n = s.b_flg[bff_pkg::FLG_FF];
  assign port_b_almost_empty_n = s.b_flg[bff_pkg::FLG_AE];
  assign port_b_almost_full_n = s.b_flg[bff_pkg::FLG_AF];
  assign port_a_parity_error_n = s.a_perr_n;
  assign port_b_parity_error_n = s.b_perr_n;
  assign a_to_b_mail_flag_n = s.mf_ab_n;
  assign b_to_a_mail_flag_n = s.mf_ba_n;
endmodule // bff_top

// *** sim/bff_props.sv ***
// Checker for the queue pair: output enables, forced parity, reset flags.
// Sees only bff_top ports; bound to every bff_top instance below.
module bff_props #(
  parameter int DEPTH = 64
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Common pins
  input wire logic device_reset_n,
  input wire logic parity_odd_select,
  // Port A
  input wire logic port_a_write_not_read,
  input wire logic port_a_mailbox_select,
  input wire logic port_a_parity_generate,
  input wire logic [35:0] port_a_data_in,
  input wire logic port_a_data_oe,
  input wire logic port_a_empty_n,
  input wire logic port_a_full_n,
  input wire logic port_a_almost_empty_n,
  input wire logic port_a_almost_full_n,
  input wire logic port_a_parity_error_n,
  input wire logic b_to_a_mail_flag_n,
  // Port B
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_write_not_read,
  input wire logic [1:0] port_b_size_select,
  input wire logic port_b_parity_generate,
  input wire logic port_b_data_oe,
  input wire logic port_b_empty_n,
  input wire logic port_b_full_n,
  input wire logic port_b_almost_full_n,
  input wire logic port_b_parity_error_n,
  input wire logic a_to_b_mail_flag_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic prev_b;
  logic [1:0] b_edges;
  wire force_a = !port_a_write_not_read && port_a_mailbox_select &&
    port_a_parity_generate;

  function automatic logic lanes_ok(input logic [35:0] d, input logic o);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++)
      ok &= (^d[9 * i +: 9]) == o;
    return ok;
  endfunction

  // Port B clock edges seen since device reset, saturating
  always_ff @(posedge clk_sys) begin
    prev_b <= port_b_clock;
    if (!device_reset_n)
      b_edges <= 2'h0;
    else if (port_b_clock && !prev_b && b_edges != 2'h3)
      b_edges <= b_edges + 2'h1;
  end

  b_released_a: assert property (
    port_b_select_n [*5] |-> !port_b_data_oe)
    else $error("port B drives while deselected");
  a_released_a: assert property (
    port_a_write_not_read [*5] |-> !port_a_data_oe)
    else $error("port A drives while writing");
  b_write_release_a: assert property (
    port_b_write_not_read [*5] |-> !port_b_data_oe)
    else $error("port B drives while writing");
  a_pe_forced_a: assert property (
    force_a [*6] |-> port_a_parity_error_n)
    else $error("port A parity error during generated mail read");
  b_pe_forced_a: assert property (
    (!port_b_write_not_read && port_b_size_select == 2'h3 &&
     port_b_parity_generate) [*6] |-> port_b_parity_error_n)
    else $error("port B parity error during generated mail read");
  a_reset_flags_a: assert property (
    !device_reset_n [*5] |-> !port_a_empty_n && !port_a_full_n &&
      !port_a_almost_empty_n && port_a_almost_full_n &&
      a_to_b_mail_flag_n && b_to_a_mail_flag_n)
    else $error("port A flags wrong in reset");
  b_reset_flags_a: assert property (
    !device_reset_n [*5] |-> !port_b_empty_n && !port_b_full_n &&
      port_b_almost_full_n)
    else $error("port B flags wrong in reset");
  b_full_rise_a: assert property (
    $rose(port_b_full_n) |-> b_edges >= 2'h2)
    else $error("port B full flag rose before second edge");
  a_parity_check_a: assert property (
    (device_reset_n && !force_a && $stable(port_a_data_in) &&
     $stable(parity_odd_select)) [*6] |->
      port_a_parity_error_n == lanes_ok(port_a_data_in, parity_odd_select))
    else $error("port A parity flag wrong");
endmodule // bff_props

bind bff_top bff_props #(.DEPTH(DEPTH)) u_props (.*);

// *** sim/bff_port_agent.sv ***
// Host model for one queue port: free-running port clock, single
// transfers. Assumes clk_sys is at least eight times the port clock.
module bff_port_agent #(
  parameter int HALF = 5
) (
  // System
  input wire logic clk_sys,
  // Port pins
  output logic pclk,
  output logic sel_n,
  output logic en,
  output logic wnr,
  output logic [35:0] din,
  input wire logic [35:0] dout,
  input wire logic oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic drv = 1'b0;
  logic [35:0] val = '0;

  initial begin
    pclk = 1'b0;
    sel_n = 1'b1;
    en = 1'b0;
    wnr = 1'b1;
  end

  // Released data lines show the inverse of the last value
  assign din = oe ? dout : (drv ? val : ~val);

  always @(posedge clk_sys) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      pclk <= ~pclk;
  end

  task automatic xfer(input logic w, input logic e, input logic [35:0] d,
                      output logic [35:0] q);
    do @(posedge clk_sys); while (!(pclk && cnt == HALF - 1));
    sel_n <= 1'b0;
    en <= e;
    wnr <= w;
    drv <= w;
    val <= d;
    repeat (HALF + 3) @(posedge clk_sys);
    sel_n <= 1'b1;
    en <= 1'b0;
    wnr <= 1'b1;
    drv <= 1'b0;
    repeat (4) @(posedge clk_sys);
    q = dout;
  endtask

  task automatic put(input logic [35:0] d);
    @(posedge clk_sys);
    drv <= 1'b1;
    val <= d;
  endtask
endmodule // bff_port_agent

// *** sim/tb.sv ***
// Self-checking bench: bus reads, queue fill and drain, swaps, sizing,
// parity and mailboxes. Port hosts are two bff_port_agent models.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 64;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  wire hready = hreadyout;
  logic device_reset_n = 1'b0, parity_odd_select = 1'b0;
  logic [1:0] offset_select = 2'h1;
  logic port_a_clock, port_a_select_n, port_a_enable, port_a_write_not_read;
  logic port_a_mailbox_select = 1'b0, port_a_parity_generate = 1'b0;
  logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in;
  logic port_a_data_oe, port_a_empty_n, port_a_full_n, port_a_almost_empty_n;
  logic port_a_almost_full_n, port_a_parity_error_n, b_to_a_mail_flag_n;
  logic port_b_clock, port_b_select_n, port_b_enable, port_b_write_not_read;
  logic [1:0] port_b_size_select = '0, port_b_swap_select = '0;
  logic port_b_lane_select_n = 1'b0, port_b_parity_generate = 1'b0;
  logic [35:0] port_b_data_out, q, seen, mem[64];
  logic port_b_data_oe, port_b_empty_n, port_b_full_n, port_b_almost_empty_n;
  logic port_b_almost_full_n, port_b_parity_error_n, a_to_b_mail_flag_n;
  int seed = 9;
  int mismatches = 0;
  int total_checks = 0;
  logic [35:0] exp_q[$];
  string name_q[$];
  event seen_ev;

  always #2 clk_sys = ~clk_sys;

  bff_top #(.DEPTH(DEPTH)) dut (.*);
  bff_port_agent #(.HALF(5)) pa (.clk_sys(clk_sys), .pclk(port_a_clock),
    .sel_n(port_a_select_n), .en(port_a_enable),
    .wnr(port_a_write_not_read), .din(port_a_data_in),
    .dout(port_a_data_out), .oe(port_a_data_oe));
  bff_port_agent #(.HALF(8)) pb (.clk_sys(clk_sys), .pclk(port_b_clock),
    .sel_n(port_b_select_n), .en(port_b_enable),
    .wnr(port_b_write_not_read), .din(port_b_data_in),
    .dout(port_b_data_out), .oe(port_b_data_oe));

  task automatic check(input string n, input logic [35:0] s,
                       input logic [35:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic obs(input string n, input logic [35:0] e,
                     input logic [35:0] s);
    exp_q.push_back(e);
    name_q.push_back(n);
    seen = s;
    -> seen_ev;
    @(posedge clk_sys);
  endtask

  // Oldest note is compared with each result that appears
  initial forever begin
    @(seen_ev);
    check(name_q.pop_front(), seen, exp_q.pop_front());
  end

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
    obs("bus response", 36'h0, 36'(hresp));
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [35:0] rnd();
    return 36'({$random(seed), $random(seed)});
  endfunction

  function automatic logic [35:0] par(input logic [35:0] d, input logic o);
    for (int i = 0; i < 4; i++)
      d[9 * i + 8] = ^d[9 * i +: 8] ^ o;
    return d;
  endfunction

  function automatic logic [35:0] swp(input logic [35:0] d, input int m);
    case (m)
      1: return {d[8:0], d[17:9], d[26:18], d[35:27]};
      2: return {d[17:0], d[35:18]};
      3: return {d[26:18], d[35:27], d[8:0], d[17:9]};
      default: return d;
    endcase
  endfunction

  function automatic logic [35:0] piece(input logic [35:0] d, input int k,
                                        input int p);
    int w;
    int j;
    logic [35:0] v;
    w = k[1] ? 9 : 18;
    j = k[0] ? p : 36 / w - 1 - p;
    v = (d >> (j * w)) & ((36'h1 << w) - 36'h1);
    return k[0] ? v : v << (36 - w);
  endfunction

  function automatic logic [35:0] flg();
    return 36'({port_a_empty_n, port_a_full_n, port_a_almost_empty_n,
      port_a_almost_full_n, port_b_empty_n, port_b_full_n,
      port_b_almost_empty_n, port_b_almost_full_n, a_to_b_mail_flag_n,
      b_to_a_mail_flag_n});
  endfunction

  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end

  initial begin
    logic [35:0] d;
    logic [31:0] r;
    int c;
    int off;
    off = bff_pkg::OFFSET_RESET[15:8];
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (80) @(posedge clk_sys);
    obs("reset flags", 36'h47, flg());
    device_reset_n <= 1'b1;
    repeat (60) @(posedge clk_sys);
    obs("flags after reset", 36'h157, flg());
    ahb(1'b0, bff_pkg::REG_OFFSETS, '0, r);
    obs("offsets reg", 36'(bff_pkg::OFFSET_RESET), 36'(r));
    ahb(1'b1, 32'h0000_0010, 32'hffff_ffff, r);
    ahb(1'b0, 32'h0000_0010, '0, r);
    obs("unmapped read", '0, 36'(r));
    pa.xfer(1'b1, 1'b0, rnd(), q);
    for (int i = 0; i <= DEPTH; i++) begin
      d = rnd();
      if (i < DEPTH)
        mem[i] = d;
      pa.xfer(1'b1, 1'b1, d, q);
      repeat (40) @(posedge clk_sys);
      c = (i < DEPTH) ? i + 1 : DEPTH;
      obs("fill flags", 36'({c > 0, c > off, DEPTH - c > off, c < DEPTH}),
        36'({port_b_empty_n, port_b_almost_empty_n, port_a_almost_full_n,
        port_a_full_n}));
    end
    for (int i = 0; i <= DEPTH; i++) begin
      pb.xfer(1'b0, 1'b1, '0, q);
      obs("queue read", mem[i < DEPTH ? i : DEPTH - 1], q);
    end
    for (int m = 0; m < 4; m++) begin
      d = rnd();
      port_b_swap_select <= 2'(m);
      pb.xfer(1'b1, 1'b1, d, q);
      repeat (60) @(posedge clk_sys);
      pa.xfer(1'b0, 1'b1, '0, q);
      obs("swapped read", swp(d, m), q);
    end
    port_b_swap_select <= 2'h0;
    for (int k = 0; k < 4; k++) begin
      port_b_size_select <= k[1] ? 2'h2 : 2'h1;
      port_b_lane_select_n <= k[0];
      repeat (50) @(posedge clk_sys);
      d = rnd();
      pa.xfer(1'b1, 1'b1, d, q);
      repeat (50) @(posedge clk_sys);
      for (int p = 0; p < (k[1] ? 4 : 2); p++) begin
        pb.xfer(1'b0, 1'b1, '0, q);
        obs("sized read", piece(d, k, p), q);
      end
    end
    for (int k = 0; k < 8; k++) begin
      parity_odd_select <= k[0];
      d = par(rnd(), k[0]);
      if (k[1])
        d[k[2] ? 35 : 8] = ~d[k[2] ? 35 : 8];
      pa.put(d);
      pb.put(d);
      repeat (12) @(posedge clk_sys);
      obs("parity flags", 36'({~k[1], ~(k[1] & ~k[2])}),
        36'({port_a_parity_error_n, port_b_parity_error_n}));
    end
    port_a_mailbox_select <= 1'b1;
    d = rnd();
    pa.xfer(1'b1, 1'b1, d, q);
    pa.xfer(1'b1, 1'b1, ~d, q);
    repeat (20) @(posedge clk_sys);
    obs("mail flags", 36'h1, flg() & 36'h3);
    port_b_size_select <= 2'h3;
    port_b_parity_generate <= 1'b1;
    pb.xfer(1'b0, 1'b1, '0, q);
    obs("b mail read", par(d, 1'b1), q);
    d = rnd();
    pb.xfer(1'b1, 1'b1, d, q);
    pb.xfer(1'b1, 1'b1, ~d, q);
    repeat (20) @(posedge clk_sys);
    obs("mail flags", 36'h2, flg() & 36'h3);
    port_a_parity_generate <= 1'b1;
    pa.xfer(1'b0, 1'b1, '0, q);
    obs("a mail read", par(d, 1'b1), q);
    repeat (20) @(posedge clk_sys);
    obs("mail flags", 36'h3, flg() & 36'h3);
    ahb(1'b1, bff_pkg::REG_OFFSETS, 32'h1122_3344, r);
    ahb(1'b0, bff_pkg::REG_OFFSETS, '0, r);
    obs("offsets write", 36'h0_1122_3344, 36'(r));
    ahb(1'b0, bff_pkg::REG_STATUS, '0, r);
    obs("latched offset", 36'h1, 36'(r[29:28]));
    // Second device reset picks another offset, one written over the bus above
    device_reset_n <= 1'b0;
    offset_select <= 2'h3;
    repeat (80) @(posedge clk_sys);
    obs("mid-run reset flags", 36'h47, flg());
    device_reset_n <= 1'b1;
    repeat (60) @(posedge clk_sys);
    obs("flags after second reset", 36'h157, flg());
    ahb(1'b0, bff_pkg::REG_STATUS, '0, r);
    obs("second latched offset", 36'h3, 36'(r[29:28]));
    report_and_stop();
  end
endmodule // tb
